//--- hdl/tcw_timer.sv
/*
  Waveform timer: 8-bit counter with normal, clear-on-match and
  fast PWM modes, compare A output unit and port override.
  Assumes a register master on the same clock that drives one-cycle
  strobes, and an external pad that resolves pinOut and pinOe.
*/
`timescale 1ns/100ps
module tcw_timer
  import tcw_pkg::*;
(
  input wire logic clk,          // System clock, 20 MHz
  input wire logic rst_n,        // Synchronous reset, active low
  input wire logic ce,           // Clock enable, freezes all state
  input wire logic [2:0] addr,   // Register index
  input wire logic [7:0] wdata,  // Write data
  input wire logic wr,           // Write strobe
  input wire logic rd,           // Read strobe
  input wire logic pinIn,        // Pad level from outside
  output logic [7:0] rdata,      // Read data, cycle after rd
  output logic pinOut,           // Pad output value
  output logic pinOe,            // Pad output enable
  output logic overflowIrq,      // overflow_flag level
  output logic compareIrqA       // compare_flag_a level
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tcw_cfg_s cfg_r, cfg_nxt;             // Mode fields and clock select
  tcw_flags_s flags_r, flags_nxt;       // Sticky flags
  logic [7:0] countValue_r, countValue_nxt;     // count_value
  logic [7:0] compareValueA_r, compareValueA_nxt; // Active compare
  logic [7:0] cmpBuf_r, cmpBuf_nxt;     // Software-side compare buffer
  logic waveOutState_r, waveOutState_nxt; // wave_out_state
  logic pinDir_r, pinDir_nxt;           // pin_direction_bit
  logic portVal_r, portVal_nxt;         // General port output
  logic blockMatch_r, blockMatch_nxt;   // Match blocked next tick
  logic matchPend_r, matchPend_nxt;     // Match waiting to set flag
  logic [7:0] rdata_r, rdata_nxt;
  logic pinOut_r, pinOut_nxt;
  logic pinOe_r, pinOe_nxt;

  logic timerTick;   // timer_tick
  logic pinSync;     // Synchronised pad level
  logic isPwm;       // Fast PWM selected
  logic [7:0] topVal;  // Top of the count
  logic atTop;       // Counter at top
  logic match;       // Counter equals compare, not blocked
  logic wrCount;     // Software write to counter
  logic wrCtrl;      // Software write to control
  logic forceHit;    // Force strobe in a non-PWM mode
  logic ovfSet;      // Overflow raised by hardware this cycle

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  tcw_prescaler u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .clkSel(cfg_r.clkSel),
    .timerTick(timerTick)
  );

  tcw_pin_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pinIn(pinIn),
    .pinSync(pinSync)
  );

  // ----------------------------------------------------------------
  // Decode of mode and compare
  // ----------------------------------------------------------------
  always_comb begin
    isPwm = (cfg_r.waveMode == WM_FAST_MAX) ||
            (cfg_r.waveMode == WM_FAST_CMPA);
    case (cfg_r.waveMode)
      WM_CLEAR_MATCH: topVal = compareValueA_r;
      WM_FAST_CMPA: topVal = compareValueA_r;
      default: topVal = CNT_MAX;
    endcase
    atTop = (countValue_r == topVal);
    // A counter write blocks compares in the tick after it
    match = (countValue_r == compareValueA_r) && !blockMatch_r;
    wrCount = wr && (addr == REG_COUNT);
    wrCtrl = wr && (addr == REG_CTRL);
    forceHit = wrCtrl && wdata[CTRL_FORCE_BIT] && !isPwm;
  end

  // ----------------------------------------------------------------
  // Counter, compare and flags
  // ----------------------------------------------------------------
  always_comb begin
    countValue_nxt = countValue_r;
    compareValueA_nxt = compareValueA_r;
    cmpBuf_nxt = cmpBuf_r;
    flags_nxt = flags_r;
    blockMatch_nxt = blockMatch_r;
    matchPend_nxt = matchPend_r;
    ovfSet = 1'b0;
    // Count sequence depends on the mode field and compare value only
    if (timerTick) begin
      blockMatch_nxt = 1'b0;
      matchPend_nxt = match;
      if (matchPend_r) begin
        flags_nxt.compareFlagA = 1'b1;
      end
      if (cfg_r.waveMode == WM_CLEAR_MATCH && match) begin
        countValue_nxt = CNT_BOTTOM;
        // A top of 0xff still steps from maximum to zero here
        if (countValue_r == CNT_MAX) begin
          ovfSet = 1'b1;
        end
      end else if (isPwm && atTop) begin
        countValue_nxt = CNT_BOTTOM;
        ovfSet = 1'b1;
      end else begin
        // Wrap to zero past maximum, even in mode two
        countValue_nxt = countValue_r + 8'h01;
        if (countValue_r == CNT_MAX) begin
          ovfSet = 1'b1;
        end
      end
      // Buffered compare copied at bottom in PWM
      if (isPwm && atTop) begin
        compareValueA_nxt = cmpBuf_r;
      end
    end
    if (ovfSet) begin
      flags_nxt.overflowFlag = 1'b1;
    end
    // Write-one-to-clear, but a set in the same cycle wins
    if (wr && addr == REG_FLAGS) begin
      if (wdata[FLAG_CMPA_BIT] && !(timerTick && matchPend_r)) begin
        flags_nxt.compareFlagA = 1'b0;
      end
      if (wdata[FLAG_OVF_BIT] && !ovfSet) begin
        flags_nxt.overflowFlag = 1'b0;
      end
    end
    // Software write to counter beats count and clear
    if (wrCount) begin
      countValue_nxt = wdata;
      blockMatch_nxt = 1'b1;
      matchPend_nxt = 1'b0;
    end
    if (wr && addr == REG_CMPA) begin
      cmpBuf_nxt = wdata;
      if (!isPwm) begin
        compareValueA_nxt = wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output compare state
  // ----------------------------------------------------------------
  always_comb begin
    waveOutState_nxt = waveOutState_r;
    // Output mode is read live, so a new value acts at next match
    if (forceHit || (timerTick && match && !isPwm)) begin
      case (cfg_r.cmpOutMode)
        COM_TOGGLE: waveOutState_nxt = !waveOutState_r;
        COM_CLEAR: waveOutState_nxt = 1'b0;
        COM_SET: waveOutState_nxt = 1'b1;
        default: waveOutState_nxt = waveOutState_r;
      endcase
    end else if (timerTick && isPwm) begin
      // Bottom action first; a match at the same tick overrides it
      if (atTop && compareValueA_r != topVal) begin
        case (cfg_r.cmpOutMode)
          COM_CLEAR: waveOutState_nxt = 1'b1;
          COM_SET: waveOutState_nxt = 1'b0;
          default: waveOutState_nxt = waveOutState_r;
        endcase
      end
      if (match) begin
        case (cfg_r.cmpOutMode)
          COM_TOGGLE: waveOutState_nxt = !waveOutState_r;
          COM_CLEAR: waveOutState_nxt = 1'b0;
          COM_SET: waveOutState_nxt = 1'b1;
          default: waveOutState_nxt = waveOutState_r;
        endcase
      end
    end
    // Preset through the pin register before enabling the pin
    if (wr && addr == REG_PIN) begin
      waveOutState_nxt = wdata[PIN_STATE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Control, pin and read data
  // ----------------------------------------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    pinDir_nxt = pinDir_r;
    portVal_nxt = portVal_r;
    if (wrCtrl) begin
      cfg_nxt.waveMode = wdata[CTRL_MODE_LSB +: 3];
      cfg_nxt.cmpOutMode = wdata[CTRL_COM_LSB +: 2];
      cfg_nxt.clkSel[1:0] = wdata[CTRL_CS_LSB +: 2];
    end
    if (wr && addr == REG_PIN) begin
      pinDir_nxt = wdata[PIN_DIR_BIT];
      portVal_nxt = wdata[PIN_PORT_BIT];
      // No room left in control, so the top select bit lives here
      cfg_nxt.clkSel[2] = wdata[PIN_CSHI_BIT];
    end
    // Override independent of waveform mode
    if (cfg_r.cmpOutMode != COM_OFF) begin
      pinOut_nxt = waveOutState_nxt;
    end else begin
      pinOut_nxt = portVal_nxt;
    end
    pinOe_nxt = pinDir_nxt;
    // Read data stand for one cycle only, zero otherwise
    rdata_nxt = 8'h00;
    if (rd) begin
      case (addr)
        REG_CTRL: rdata_nxt = {cfg_r.clkSel[1:0], 1'b0,
                               cfg_r.cmpOutMode, cfg_r.waveMode};
        REG_COUNT: rdata_nxt = countValue_r;
        REG_CMPA: rdata_nxt = cmpBuf_r;
        REG_FLAGS: rdata_nxt = {6'h00, flags_r};
        REG_PIN: rdata_nxt = {3'h0, cfg_r.clkSel[2], pinSync, waveOutState_r,
                              portVal_r, pinDir_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_r <= '0;
      flags_r <= '0;
      countValue_r <= RST_BYTE;
      compareValueA_r <= RST_BYTE;
      cmpBuf_r <= RST_BYTE;
      waveOutState_r <= 1'b0;
      pinDir_r <= 1'b0;
      portVal_r <= 1'b0;
      blockMatch_r <= 1'b0;
      matchPend_r <= 1'b0;
      rdata_r <= 8'h00;
      pinOut_r <= 1'b0;
      pinOe_r <= 1'b0;
    end else if (ce) begin
      cfg_r <= cfg_nxt;
      flags_r <= flags_nxt;
      countValue_r <= countValue_nxt;
      compareValueA_r <= compareValueA_nxt;
      cmpBuf_r <= cmpBuf_nxt;
      waveOutState_r <= waveOutState_nxt;
      pinDir_r <= pinDir_nxt;
      portVal_r <= portVal_nxt;
      blockMatch_r <= blockMatch_nxt;
      matchPend_r <= matchPend_nxt;
      rdata_r <= rdata_nxt;
      pinOut_r <= pinOut_nxt;
      pinOe_r <= pinOe_nxt;
    end
  end

  assign rdata = rdata_r;
  assign pinOut = pinOut_r;
  assign pinOe = pinOe_r;
  assign overflowIrq = flags_r.overflowFlag;
  assign compareIrqA = flags_r.compareFlagA;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  normal_wrap_a: assert property (
    ce && timerTick && !wr && cfg_r.waveMode == WM_NORMAL &&
    countValue_r == CNT_MAX |=> countValue_r == CNT_BOTTOM)
    else $error("normal mode did not wrap");
  ovf_at_wrap_a: assert property (
    ce && timerTick && !wr && countValue_r == CNT_MAX &&
    (cfg_r.waveMode == WM_NORMAL || cfg_r.waveMode == WM_CLEAR_MATCH)
    |=> flags_r.overflowFlag)
    else $error("overflow flag not set at wrap");
  ctc_clear_a: assert property (
    ce && timerTick && !wr && cfg_r.waveMode == WM_CLEAR_MATCH && match
    |=> countValue_r == CNT_BOTTOM)
    else $error("clear-on-match did not clear");
  pwm_top_a: assert property (
    ce && timerTick && !wr && isPwm && atTop
    |=> countValue_r == CNT_BOTTOM && flags_r.overflowFlag)
    else $error("fast pwm did not restart at top");
  flag_delay_a: assert property (
    ce && timerTick && match && !wr ##1 ce && timerTick
    |=> flags_r.compareFlagA)
    else $error("compare flag not set a tick after match");
  write_prio_a: assert property (
    ce && wrCount |=> countValue_r == $past(wdata))
    else $error("counter write lost");
  pin_enable_a: assert property (
    ce && wr && addr == REG_PIN |=> pinOe == $past(wdata[PIN_DIR_BIT]))
    else $error("pin enable not following direction");
  com_zero_a: assert property (
    ce && !wr && cfg_r.cmpOutMode == COM_OFF
    |=> waveOutState_r == $past(waveOutState_r))
    else $error("state changed with output mode zero");
  force_noflag_a: assert property (
    ce && forceHit && !timerTick && !matchPend_r
    |=> flags_r.compareFlagA == $past(flags_r.compareFlagA))
    else $error("force changed compare flag");
  // Force, pin, flag and buffer checks
  force_count_a: assert property (
    ce && forceHit && !timerTick |=> countValue_r == $past(countValue_r))
    else $error("force moved the counter");
  override_on_a: assert property (
    ce && cfg_r.cmpOutMode != COM_OFF |=> pinOut == waveOutState_r)
    else $error("pin not showing compare state");
  port_value_a: assert property (
    ce && cfg_r.cmpOutMode == COM_OFF |=> pinOut == portVal_r)
    else $error("pin not showing port value");
  flag_clear_a: assert property (
    ce && wr && addr == REG_FLAGS && wdata[FLAG_CMPA_BIT] && !timerTick
    |=> !flags_r.compareFlagA)
    else $error("compare flag not cleared by write");
  set_wins_a: assert property (
    ce && ovfSet |=> flags_r.overflowFlag)
    else $error("overflow set lost to clear");
  pwm_copy_a: assert property (
    ce && timerTick && isPwm && atTop && !wr |=> compareValueA_r == $past(cmpBuf_r))
    else $error("buffered compare not copied at top");

  // Main scenarios worth seeing in a run
  cover_ctc_c: cover property (
    timerTick && cfg_r.waveMode == WM_CLEAR_MATCH && match);
  cover_pwm_c: cover property (timerTick && isPwm && atTop);
  cover_force_c: cover property (forceHit);
  cover_block_c: cover property (timerTick && blockMatch_r);

endmodule // tcw_timer

//--- inc/tcw_pkg.sv
/*
  Package of the waveform timer: mode and compare-output encodings,
  register indices of the plain register port, field positions,
  reset values, prescaler choices and the packed structs that carry
  the configuration and the status between the files.
  Assumes one 20 MHz clock and a single-cycle register port.
*/
// Behaviour
// - Output mode zero leaves state alone on match
// - Nonzero output mode puts state on pin
// - Pin driven only when direction bit set
// - Pin override same in every waveform mode
// - State presettable, holds until match, force or PWM bottom
// - New output mode acts at next match
// - Mode select sets count, output mode sets action
// - Normal mode counts up, wraps FF to 00
// - Overflow flag set at wrap, hardware never clears
// - Counter writable any time in normal mode
// - Mode two clears counter on compare A
// - Compare A flag raised a tick after top in mode two
// - Mode two compare written unbuffered, may wrap
// - Mode two output mode one toggles output
// - Modes 3 and 7 fast PWM, tops FF/A
// - Fast PWM counts to top, then zero
// - PWM mode two clear-set, three set-clear
// - Fast PWM overflow flag set at top
// - Compare zero spikes, maximum gives steady level
// - PWM output mode one toggles, buffered compare
// - Tick from clock divided by seven ratios
// - Match sets flag next tick, write-one clears
// - Counter write blocks next match, has priority
// - PWM compare buffered, copied at bottom
// - Force applies action in non-PWM modes, no flag, no clear
package tcw_pkg;

  // ----------------------------------------------------------------
  // Register indices of the plain register port
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CTRL = 3'h0;   // Modes, force, clock select
  localparam logic [2:0] REG_COUNT = 3'h1;  // Counter value
  localparam logic [2:0] REG_CMPA = 3'h2;   // Compare value A
  localparam logic [2:0] REG_FLAGS = 3'h3;  // Flags, write one to clear
  localparam logic [2:0] REG_PIN = 3'h4;    // Direction, port value, state

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;     // wave_mode_sel [2:0]
  localparam int CTRL_COM_LSB = 3;      // cmp_out_mode_a [4:3]
  localparam int CTRL_FORCE_BIT = 5;    // force_compare_strobe
  localparam int CTRL_CS_LSB = 6;       // Clock select [7:6] + ext bit
  localparam int FLAG_OVF_BIT = 0;      // overflow_flag
  localparam int FLAG_CMPA_BIT = 1;     // compare_flag_a
  localparam int PIN_DIR_BIT = 0;       // pin_direction_bit
  localparam int PIN_PORT_BIT = 1;      // General port output value
  localparam int PIN_STATE_BIT = 2;     // wave_out_state preset
  localparam int PIN_CSHI_BIT = 4;      // Clock select bit 2

  // ----------------------------------------------------------------
  // Encodings and values
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WM_NORMAL = 3'h0,
    WM_CLEAR_MATCH = 3'h2,
    WM_FAST_MAX = 3'h3,
    WM_FAST_CMPA = 3'h7
  } tcw_mode_e;

  localparam logic [1:0] COM_OFF = 2'h0;      // No action
  localparam logic [1:0] COM_TOGGLE = 2'h1;   // Toggle on match
  localparam logic [1:0] COM_CLEAR = 2'h2;    // Clear (PWM: clear/set)
  localparam logic [1:0] COM_SET = 2'h3;      // Set (PWM: set/clear)
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] CS_STOP = 3'h0;      // Timer stopped

  // Division ratios for clock select 1..7 minus one
  localparam logic [9:0] DIV_1 = 10'h000;
  localparam logic [9:0] DIV_8 = 10'h007;
  localparam logic [9:0] DIV_32 = 10'h01f;
  localparam logic [9:0] DIV_64 = 10'h03f;
  localparam logic [9:0] DIV_128 = 10'h07f;
  localparam logic [9:0] DIV_256 = 10'h0ff;
  localparam logic [9:0] DIV_1024 = 10'h3ff;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] clkSel;      // Clock select, 0 stops
    logic [1:0] cmpOutMode;  // cmp_out_mode_a
    logic [2:0] waveMode;    // wave_mode_sel
  } tcw_cfg_s;

  typedef struct packed {
    logic compareFlagA;  // compare_flag_a
    logic overflowFlag;  // overflow_flag
  } tcw_flags_s;

endpackage

//--- hdl/tcw_prescaler.sv
/*
  Prescaler: turns the system clock into the one-cycle timer tick.
  Assumes the clock enable and clock select come from the same clock.
*/
`timescale 1ns/100ps
module tcw_prescaler
  import tcw_pkg::*;
(
  input wire logic clk,           // System clock
  input wire logic rst_n,         // Synchronous reset, active low
  input wire logic ce,            // Clock enable
  input wire logic [2:0] clkSel,  // Clock select
  output logic timerTick          // One-cycle timer tick
);

  logic [9:0] divCnt_r;  // Free running divider
  logic [9:0] divCnt_nxt;
  logic timerTick_r;
  logic timerTick_nxt;
  logic [9:0] limit;  // Terminal count for the selected ratio

  // ----------------------------------------------------------------
  // Ratio select and divider
  // ----------------------------------------------------------------
  always_comb begin
    case (clkSel)
      3'h1: limit = DIV_1;
      3'h2: limit = DIV_8;
      3'h3: limit = DIV_32;
      3'h4: limit = DIV_64;
      3'h5: limit = DIV_128;
      3'h6: limit = DIV_256;
      3'h7: limit = DIV_1024;
      default: limit = DIV_1;
    endcase
    // A shared divider: changing ratio may shorten one period
    if (clkSel == CS_STOP || divCnt_r >= limit) begin
      divCnt_nxt = 10'h000;
    end else begin
      divCnt_nxt = divCnt_r + 10'h001;
    end
    timerTick_nxt = (clkSel != CS_STOP) && (divCnt_r >= limit);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt_r <= 10'h000;
      timerTick_r <= 1'b0;
    end else if (ce) begin
      divCnt_r <= divCnt_nxt;
      timerTick_r <= timerTick_nxt;
    end
  end

  assign timerTick = timerTick_r && ce;

endmodule // tcw_prescaler

//--- hdl/tcw_pin_sync.sv
/*
  Two-flop synchroniser for the port pin level read back by software.
  Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/100ps
module tcw_pin_sync (
  input wire logic clk,     // System clock
  input wire logic rst_n,   // Synchronous reset, active low
  input wire logic ce,      // Clock enable
  input wire logic pinIn,   // Raw pin level
  output logic pinSync      // Synchronised level
);

  logic meta_r;  // First stage, read only by the second
  logic sync_r;  // Second stage

  // ----------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else if (ce) begin
      meta_r <= pinIn;
      sync_r <= meta_r;
    end
  end

  assign pinSync = sync_r;

endmodule // tcw_pin_sync

//--- bench/tcw_pad_load.sv
/*
  External load on the timer's port pin: a pad with a pull-up resistor.
  Assumes pinOut and pinOe come straight from the timer's pad outputs.
*/
`timescale 1ns/100ps
module tcw_pad_load (
  input wire logic pinOut,  // Value driven by the timer
  input wire logic pinOe,   // High while the timer drives the pad
  output logic padLevel     // Resolved pad level
);
  // ------------------------------------------------------------------
  // Pad resolution
  // ------------------------------------------------------------------
  // Pull-up wins when nobody drives, so a released pad never shows
  // the last driven value by accident
  assign padLevel = pinOe ? pinOut : 1'b1;
endmodule // tcw_pad_load

//--- bench/timer_compare_waveform_modes_tb.sv
/*
  Self-checking bench of the waveform timer: register access, pin
  override, force, and the waveform of every mode, measured on the pad.
  Assumes the prescaler ticks on every clock with clock select one.
*/
`timescale 1ns/100ps
module timer_compare_waveform_modes_tb;
  import tcw_pkg::*;
  logic clk, rst_n, wr, rd;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic pinOut, pinOe, overflowIrq, compareIrqA, padLevel;
  int fails, tests_run, cyc, hi, lo, n;

  tcw_timer u_tcw_timer (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .pinIn(padLevel),
    .rdata(rdata), .pinOut(pinOut), .pinOe(pinOe),
    .overflowIrq(overflowIrq), .compareIrqA(compareIrqA));
  tcw_pad_load u_tcw_pad_load (.pinOut(pinOut), .pinOe(pinOe),
    .padLevel(padLevel));

  // ------------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------------
  always #25 clk = ~clk;
  // Whole run needs about 4700 cycles, so 20000 means a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("[FAIL] %0t timeout", $time);
      finish_test();
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic finish_test();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Range compare for measured cycle counts
  task automatic chkr(input int got, input int lo_, input int hi_,
                      input string m);
    tests_run++;
    if (got < lo_ || got > hi_) begin
      fails++;
      $display("[FAIL] %0t %s got %0d", $time, m, got);
    end
  endtask

  // One-cycle write strobe, released after the taking edge
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the taking edge
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Pad outputs lag the register write by one cycle
  task automatic pin_chk(input logic o, input logic e, input string m);
    repeat (2) @(posedge clk);
    #1;
    chk({6'h0, pinOe, pinOut}, {6'h0, e, o}, m);
  endtask

  // Bounded wait for a pad level, returning cycles spent
  task automatic waitlvl(input logic v, output int c);
    c = 0;
    while (pinOut !== v && c < 2000) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask

  // Configure a mode while stopped, run it, measure one full period
  task automatic run_wave(input logic [2:0] md, input logic [1:0] com,
      input logic [7:0] cmp, input int eHi, input int ePer,
      input logic [7:0] eFlg);
    wr_reg(REG_CTRL, 8'h00);
    wr_reg(REG_COUNT, 8'h00);
    // Compare written in a non-PWM mode so it lands directly
    wr_reg(REG_CMPA, cmp);
    wr_reg(REG_FLAGS, 8'h03);
    wr_reg(REG_PIN, 8'h01);
    wr_reg(REG_CTRL, {2'h1, 1'b0, com, md});
    waitlvl(1'b0, n);
    waitlvl(1'b1, n);
    waitlvl(1'b0, hi);
    waitlvl(1'b1, lo);
    chkr(hi, eHi - 1, eHi + 1, "high time");
    chkr(hi + lo, ePer, ePer, "period");
    rd_reg(REG_FLAGS, rv);
    chk(rv, eFlg, "flags");
    chk({6'h0, compareIrqA, overflowIrq}, eFlg, "flag levels");
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    fails = 0;
    tests_run = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    pin_chk(1'b0, 1'b0, "reset pad");
    rd_reg(REG_CTRL, rv);
    chk(rv, 8'h00, "reset ctrl");
    rd_reg(REG_PIN, rv);
    chk(rv, 8'h08, "reset pin");
    // Unmapped places read zero and ignore writes
    wr_reg(3'h5, 8'hff);
    rd_reg(3'h5, rv);
    chk(rv, 8'h00, "unmapped");
    wr_reg(REG_COUNT, 8'h5a);
    rd_reg(REG_COUNT, rv);
    chk(rv, 8'h5a, "count write");
    // Preset state with the pad still an input
    wr_reg(REG_PIN, 8'h04);
    wr_reg(REG_CTRL, 8'h08);
    pin_chk(1'b1, 1'b0, "preset undriven");
    rd_reg(REG_PIN, rv);
    chk(rv, 8'h0c, "preset held");
    wr_reg(REG_PIN, 8'h05);
    pin_chk(1'b1, 1'b1, "override on");
    // Force toggles state without flag or counter clear
    wr_reg(REG_CTRL, 8'h28);
    pin_chk(1'b0, 1'b1, "force toggle");
    rd_reg(REG_FLAGS, rv);
    chk(rv, 8'h00, "force no flag");
    rd_reg(REG_COUNT, rv);
    chk(rv, 8'h5a, "force no clear");
    // Output mode off gives the port bit back, force does nothing
    wr_reg(REG_CTRL, 8'h00);
    wr_reg(REG_PIN, 8'h03);
    pin_chk(1'b1, 1'b1, "port value");
    wr_reg(REG_CTRL, 8'h20);
    rd_reg(REG_PIN, rv);
    chk(rv, 8'h0b, "mode off keeps state");
    // Waveform table: mode, output mode, compare, high, period, flags
    run_wave(3'h0, COM_TOGGLE, 8'h80, 256, 512, 8'h03);
    run_wave(3'h2, COM_TOGGLE, 8'h04, 5, 10, 8'h02);
    run_wave(3'h3, COM_CLEAR, 8'h40, 65, 256, 8'h03);
    run_wave(3'h3, COM_SET, 8'h40, 191, 256, 8'h03);
    run_wave(3'h7, COM_TOGGLE, 8'h20, 33, 66, 8'h03);
    run_wave(3'h3, COM_CLEAR, 8'h00, 1, 256, 8'h03);
    // Compare below the count: run to the maximum and wrap first
    wr_reg(REG_CTRL, 8'h00);
    wr_reg(REG_CMPA, 8'h04);
    wr_reg(REG_COUNT, 8'h10);
    wr_reg(REG_PIN, 8'h01);
    wr_reg(REG_CTRL, {2'h1, 1'b0, COM_TOGGLE, 3'h2});
    waitlvl(1'b1, n);
    chkr(n, 238, 250, "late match");
    // Compare at the maximum: mode two toggles, fast PWM holds a steady level, no edge in two periods
    run_wave(3'h2, COM_TOGGLE, 8'hff, 256, 512, 8'h03);
    wr_reg(REG_CTRL, {2'h1, 1'b0, COM_CLEAR, 3'h3});
    repeat (260) @(posedge clk);
    #1;
    rv = {7'h0, pinOut};
    n = 0;
    repeat (520) begin
      @(posedge clk);
      #1;
      if (pinOut !== rv[0]) n = -1;
    end
    chkr(n, 0, 0, "steady level");
    chk(rv, 8'h00, "steady polarity");
    // Top select bit in the pin register: divide by 64
    wr_reg(REG_CTRL, 8'h00);
    wr_reg(REG_COUNT, 8'h00);
    wr_reg(REG_PIN, 8'h10);
    repeat (640) @(posedge clk);
    rd_reg(REG_COUNT, rv);
    chkr(rv, 9, 11, "divide by 64");
    finish_test();
  end
endmodule // timer_compare_waveform_modes_tb
